// ===== hdl/tcc_top.sv
// One 16-bit timer channel with clock select, clear select and register A
// compare/capture, reached over an Avalon-MM slave with waitrequest.
// Assumes one 20 MHz clock, async active-high reset, async pins.
//
// What this block does
// - Clock field codes 0-3 pick clk/1,/2,/4,/8; codes 4-7 external inputs A-D.
// - Register-A function 000: compare register, pin unchanged on match.
// - Register-A function 001: pin driven low on compare match.
// - Register-A function 010: pin driven high on compare match.
// - Register-A function 011: pin toggles on every compare match.
// - Register-A function 100: capture counter on rising input edge.
// - Register-A function 101: capture counter on falling input edge.
// - Register-A function 110: capture counter on both input edges.
`default_nettype none

module tcc_top (
    input  wire logic        clk,
    input  wire logic        rst,
    // Avalon-MM slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Pins
    input  wire logic [3:0]  ext_clock_in,
    input  wire logic        ioa_pin_in,
    output logic             ioa_pin_out,
    output logic             ioa_pin_oe,
    // Channel synchronisation
    input  wire logic        sync_clear_in,
    output logic             clear_event
);
    typedef struct packed {
        logic [6:0]  ctl;
        logic [2:0]  ioa;
        logic [2:0]  iob;
        logic [15:0] cnt;
        logic [15:0] gra;
        logic [15:0] general_register_b;
        logic        pin_lvl;
        logic        pin_oe;
        logic        clr_evt;
        logic        wait_req;
        logic [31:0] rdata;
    } tcc_top_state_type;

    tcc_top_state_type s_r;
    tcc_top_state_type s_nxt;

    tcc_link_if lnk ();

    // Count clock selection
    tcc_clk_sel u_clk_sel (
        .clk          (clk),
        .rst          (rst),
        .ext_clock_in (ext_clock_in),
        .lnk          (lnk)
    );

    // Capture input monitor
    tcc_pin_edge u_pin_edge (
        .clk    (clk),
        .rst    (rst),
        .pin_in (ioa_pin_in),
        .lnk    (lnk)
    );

    // Merge a 16-bit register with the low two byte lanes
    function automatic logic [15:0] merge16(
        input logic [15:0] old,
        input logic [31:0] wd,
        input logic [3:0]  be
    );
        logic [15:0] res;
        res = old;
        if (be[0]) begin
            res[7:0] = wd[7:0];
        end
        if (be[1]) begin
            res[15:8] = wd[15:8];
        end
        return res;
    endfunction

    // Read value of an address, zero when unmapped
    function automatic logic [31:0] read_mux(
        input tcc_top_state_type st,
        input logic [7:0]        addr,
        input logic              pin_sync
    );
        logic [31:0] v;
        v = 32'h0000_0000;
        unique case (addr)
            tcc_pkg::ADDR_CTL: v = {24'h00_0000, tcc_pkg::CTL_RSVD_MASK | {1'b0, st.ctl}};
            tcc_pkg::ADDR_IOC: v = {24'h00_0000,
                                    tcc_pkg::IOC_RSVD_MASK | {1'b0, st.iob, 1'b0, st.ioa}};
            tcc_pkg::ADDR_CNT: v = {16'h0000, st.cnt};
            tcc_pkg::ADDR_GRA: v = {16'h0000, st.gra};
            tcc_pkg::ADDR_GRB: v = {16'h0000, st.general_register_b};
            tcc_pkg::ADDR_STAT: begin
                v[tcc_pkg::STAT_PIN_LVL] = st.pin_lvl;
                v[tcc_pkg::STAT_PIN_IN]  = pin_sync;
            end
            default: v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    // Control fields toward the clock selector
    assign lnk.clk_sel  = s_r.ctl[tcc_pkg::CTL_SRC_LSB +: 3];
    assign lnk.edge_sel = s_r.ctl[tcc_pkg::CTL_EDGE_LSB +: 2];

    // Next state of the channel and the bus slave
    always_comb begin
        logic [1:0] clr_sel;
        logic       is_cap;
        logic       match_a;
        logic       match_b;
        logic       cap_a;
        logic       do_clear;
        logic       commit;
        clr_sel  = s_r.ctl[tcc_pkg::CTL_CLR_LSB +: 2];
        is_cap   = s_r.ioa[2];
        match_a  = 1'b0;
        match_b  = 1'b0;
        cap_a    = 1'b0;
        do_clear = 1'b0;
        commit   = 1'b0;
        s_nxt    = s_r;

        // Compare match when the counter leaves a value equal to a register
        match_a = lnk.tick && !is_cap && (s_r.cnt == s_r.gra);
        match_b = lnk.tick && (s_r.cnt == s_r.general_register_b);

        // Capture edge qualification
        unique case (s_r.ioa)
            tcc_pkg::IOA_CAP_RISE: cap_a = lnk.cap_rise;
            tcc_pkg::IOA_CAP_FALL: cap_a = lnk.cap_fall;
            tcc_pkg::IOA_CAP_BOTH: cap_a = lnk.cap_rise | lnk.cap_fall;
            default:               cap_a = 1'b0;
        endcase

        unique case (clr_sel)
            tcc_pkg::CLR_NONE: do_clear = 1'b0;
            tcc_pkg::CLR_A:    do_clear = match_a | cap_a;
            tcc_pkg::CLR_B:    do_clear = match_b;
            tcc_pkg::CLR_SYNC: do_clear = sync_clear_in;
        endcase
        s_nxt.clr_evt = do_clear;

        // Counter advance or clear
        if (do_clear) begin
            s_nxt.cnt = 16'h0000;
        end else if (lnk.tick) begin
            s_nxt.cnt = s_r.cnt + 16'h0001;
        end

        // Output pin action on register-A match
        unique case (s_r.ioa)
            tcc_pkg::IOA_NONE:   s_nxt.pin_lvl = s_r.pin_lvl;
            tcc_pkg::IOA_LOW:    s_nxt.pin_lvl = match_a ? 1'b0 : s_r.pin_lvl;
            tcc_pkg::IOA_HIGH:   s_nxt.pin_lvl = match_a ? 1'b1 : s_r.pin_lvl;
            tcc_pkg::IOA_TOGGLE: s_nxt.pin_lvl = s_r.pin_lvl ^ match_a;
            default:             s_nxt.pin_lvl = s_r.pin_lvl;
        endcase
        s_nxt.pin_oe = !is_cap && (s_r.ioa != tcc_pkg::IOA_NONE);

        // Bus handshake: answer one cycle after the request appears
        commit = avs_write && !s_r.wait_req;
        if ((avs_read || avs_write) && s_r.wait_req) begin
            s_nxt.wait_req = 1'b0;
            s_nxt.rdata = avs_read ? read_mux(s_r, avs_address, lnk.pin_lvl) : 32'h0000_0000;
        end else begin
            s_nxt.wait_req = 1'b1;
        end

        // Register writes; bus write to the counter wins over counting
        if (commit) begin
            unique case (avs_address)
                tcc_pkg::ADDR_CTL: begin
                    if (avs_byteenable[0]) begin
                        s_nxt.ctl = avs_writedata[6:0];
                    end
                end
                tcc_pkg::ADDR_IOC: begin
                    if (avs_byteenable[0]) begin
                        s_nxt.ioa = avs_writedata[tcc_pkg::IOC_A_LSB +: 3];
                        s_nxt.iob = avs_writedata[tcc_pkg::IOC_B_LSB +: 3];
                    end
                end
                tcc_pkg::ADDR_CNT: s_nxt.cnt = merge16(s_r.cnt, avs_writedata, avs_byteenable);
                tcc_pkg::ADDR_GRA: s_nxt.gra = merge16(s_r.gra, avs_writedata, avs_byteenable);
                tcc_pkg::ADDR_GRB: s_nxt.general_register_b = merge16(s_r.general_register_b, avs_writedata, avs_byteenable);
                default: begin
                end
            endcase
        end

        // Capture wins over a bus write to register A
        if (cap_a) begin
            s_nxt.gra = s_r.cnt;
        end
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r.ctl      <= tcc_pkg::CTL_RESET;
            s_r.ioa      <= tcc_pkg::IOC_RESET;
            s_r.iob      <= tcc_pkg::IOC_RESET;
            s_r.cnt      <= tcc_pkg::CNT_RESET;
            s_r.gra      <= tcc_pkg::GR_RESET;
            s_r.general_register_b      <= tcc_pkg::GR_RESET;
            s_r.pin_lvl  <= 1'b0;
            s_r.pin_oe   <= 1'b0;
            s_r.clr_evt  <= 1'b0;
            s_r.wait_req <= 1'b1;
            s_r.rdata    <= 32'h0000_0000;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs straight from flops
    assign avs_readdata    = s_r.rdata;
    assign avs_waitrequest = s_r.wait_req;
    assign ioa_pin_out     = s_r.pin_lvl;
    assign ioa_pin_oe      = s_r.pin_oe;
    assign clear_event     = s_r.clr_evt;
endmodule // tcc_top

`default_nettype wire

// ===== hdl/tcc_pkg.sv
// Constants for the timer channel clock and register-A control block.
// Assumes a 32-bit Avalon-MM slave with byte addresses on the register side.
`default_nettype none

package tcc_pkg;
    // Register byte offsets
    localparam logic [7:0]  ADDR_CTL      = 8'h64;
    localparam logic [7:0]  ADDR_IOC      = 8'h68;
    localparam logic [7:0]  ADDR_CNT      = 8'h6C;
    localparam logic [7:0]  ADDR_GRA      = 8'h70;
    localparam logic [7:0]  ADDR_GRB      = 8'h74;
    localparam logic [7:0]  ADDR_STAT     = 8'h78;

    // Control register fields
    localparam int          CTL_SRC_LSB   = 0;
    localparam int          CTL_EDGE_LSB  = 3;
    localparam int          CTL_CLR_LSB   = 5;
    localparam logic [7:0]  CTL_RSVD_MASK = 8'h80;
    localparam logic [6:0]  CTL_RESET     = 7'h00;

    // Compare/capture control fields
    localparam int          IOC_A_LSB     = 0;
    localparam int          IOC_B_LSB     = 4;
    localparam logic [7:0]  IOC_RSVD_MASK = 8'h88;
    localparam logic [2:0]  IOC_RESET     = 3'h0;

    // Data register reset values
    localparam logic [15:0] CNT_RESET     = 16'h0000;
    localparam logic [15:0] GR_RESET      = 16'hFFFF;

    // Clock source codes
    localparam logic [2:0]  SRC_DIV1      = 3'h0;
    localparam logic [2:0]  SRC_DIV2      = 3'h1;
    localparam logic [2:0]  SRC_DIV4      = 3'h2;
    localparam logic [2:0]  SRC_DIV8      = 3'h3;

    // External edge codes
    localparam logic [1:0]  EDGE_RISE     = 2'h0;
    localparam logic [1:0]  EDGE_FALL     = 2'h1;

    // Clear source codes
    localparam logic [1:0]  CLR_NONE      = 2'h0;
    localparam logic [1:0]  CLR_A         = 2'h1;
    localparam logic [1:0]  CLR_B         = 2'h2;
    localparam logic [1:0]  CLR_SYNC      = 2'h3;

    // Register-A function codes
    localparam logic [2:0]  IOA_NONE      = 3'h0;
    localparam logic [2:0]  IOA_LOW       = 3'h1;
    localparam logic [2:0]  IOA_HIGH      = 3'h2;
    localparam logic [2:0]  IOA_TOGGLE    = 3'h3;
    localparam logic [2:0]  IOA_CAP_RISE  = 3'h4;
    localparam logic [2:0]  IOA_CAP_FALL  = 3'h5;
    localparam logic [2:0]  IOA_CAP_BOTH  = 3'h6;

    // Status bits
    localparam int          STAT_PIN_LVL  = 0;
    localparam int          STAT_PIN_IN   = 1;

    // Prescaler divider counter width and terminal counts
    localparam int          DIV_W         = 3;
    localparam logic [2:0]  DIV2_MASK     = 3'h1;
    localparam logic [2:0]  DIV4_MASK     = 3'h3;
    localparam logic [2:0]  DIV8_MASK     = 3'h7;
endpackage

`default_nettype wire

// ===== hdl/tcc_if.sv
// Internal carrier between the channel core, its clock selector and pin monitor.
// Assumes all three sit on the same clock.
`default_nettype none

interface tcc_link_if;
    logic       tick;      // Counter advance pulse
    logic [2:0] clk_sel;   // Clock source field
    logic [1:0] edge_sel;  // External edge field
    logic       cap_rise;  // Rising edge on capture input
    logic       cap_fall;  // Falling edge on capture input
    logic       pin_lvl;   // Synchronised capture input level

    modport clk_src (input clk_sel, input edge_sel, output tick);
    modport pin_mon (output cap_rise, output cap_fall, output pin_lvl);
    modport core    (input tick, input cap_rise, input cap_fall, input pin_lvl,
                     output clk_sel, output edge_sel);
endinterface

`default_nettype wire

// ===== hdl/tcc_clk_sel.sv
// Count-clock selector: prescaler and external clock edge detection.
// Assumes external clock pins are asynchronous to clk.
`default_nettype none

module tcc_clk_sel (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [3:0]   ext_clock_in,
    tcc_link_if.clk_src       lnk
);
    typedef struct packed {
        logic [tcc_pkg::DIV_W-1:0] div;
        logic [3:0]                s1;
        logic [3:0]                s2;
        logic [3:0]                prev;
        logic                      tick;
    } tcc_clk_state_type;

    tcc_clk_state_type s_r;
    tcc_clk_state_type s_nxt;

    // Next state: divider, synchronisers, tick select
    always_comb begin
        logic cur;
        logic old;
        cur = 1'b0;
        old = 1'b0;
        s_nxt = s_r;
        s_nxt.div = s_r.div + 3'h1;
        s_nxt.s1 = ext_clock_in;
        s_nxt.s2 = s_r.s1;
        s_nxt.prev = s_r.s2;
        cur = s_r.s2[lnk.clk_sel[1:0]];
        old = s_r.prev[lnk.clk_sel[1:0]];
        if (lnk.clk_sel[2]) begin
            if (lnk.edge_sel == tcc_pkg::EDGE_RISE) begin
                s_nxt.tick = cur & ~old;
            end else if (lnk.edge_sel == tcc_pkg::EDGE_FALL) begin
                s_nxt.tick = ~cur & old;
            end else begin
                s_nxt.tick = cur ^ old;
            end
        end else begin
            unique case (lnk.clk_sel)
                tcc_pkg::SRC_DIV1: s_nxt.tick = 1'b1;
                tcc_pkg::SRC_DIV2: s_nxt.tick = (s_r.div & tcc_pkg::DIV2_MASK) == 3'h1;
                tcc_pkg::SRC_DIV4: s_nxt.tick = (s_r.div & tcc_pkg::DIV4_MASK) == 3'h3;
                default:           s_nxt.tick = (s_r.div & tcc_pkg::DIV8_MASK) == 3'h7;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign lnk.tick = s_r.tick;
endmodule // tcc_clk_sel

`default_nettype wire

// ===== hdl/tcc_pin_edge.sv
// Capture input monitor: two-flop synchroniser and edge pulses.
// Assumes the capture pin is asynchronous to clk.
`default_nettype none

module tcc_pin_edge (
    input  wire logic    clk,
    input  wire logic    rst,
    input  wire logic    pin_in,
    tcc_link_if.pin_mon  lnk
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic prev;
        logic rise;
        logic fall;
    } tcc_pin_state_type;

    tcc_pin_state_type s_r;
    tcc_pin_state_type s_nxt;

    // Synchronise, then compare second flop with its delayed copy
    always_comb begin
        s_nxt = s_r;
        s_nxt.s1 = pin_in;
        s_nxt.s2 = s_r.s1;
        s_nxt.prev = s_r.s2;
        s_nxt.rise = s_r.s2 & ~s_r.prev;
        s_nxt.fall = ~s_r.s2 & s_r.prev;
    end

    // State register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign lnk.cap_rise = s_r.rise;
    assign lnk.cap_fall = s_r.fall;
    assign lnk.pin_lvl  = s_r.prev;
endmodule // tcc_pin_edge

`default_nettype wire

// ===== bench/tcc_pin_model.sv
// Far-side pins: four external count clocks and the capture input.
// Assumes the bench calls its tasks; pins change just after clk edges.
`default_nettype none

module tcc_pin_model (
    input  wire logic       clk,
    output logic      [3:0] ext_clock_in,
    output logic            ioa_pin_in
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle low between bursts
    initial begin
        ext_clock_in = 4'h0;
        ioa_pin_in = 1'b0;
    end

    // Burst of n periods, 4 clk high then 4 low
    task automatic burst(input int p, input int n);
        repeat (n) begin
            @(posedge clk);
            ext_clock_in[p] <= 1'b1;
            repeat (4) @(posedge clk);
            ext_clock_in[p] <= 1'b0;
            repeat (3) @(posedge clk);
        end
    endtask

    // One capture input edge, then settle time
    task automatic cap(input logic v);
        @(posedge clk);
        ioa_pin_in <= v;
        repeat (8) @(posedge clk);
    endtask
endmodule // tcc_pin_model

`default_nettype wire

// ===== bench/tcc_top_checker.sv
// Checker for the timer channel: bus handshake, pin modes, clear events.
// Sees only tcc_top ports; bound to every tcc_top instance.
`default_nettype none

module tcc_top_checker (
    input wire logic        clk,
    input wire logic        rst,
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        ioa_pin_out,
    input wire logic        ioa_pin_oe,
    input wire logic        sync_clear_in,
    input wire logic        clear_event
);
    logic [6:0] ctl_r;
    logic [2:0] mode_r;

    // Shadow of control and register-A function fields
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctl_r <= 7'h00;
            mode_r <= 3'h0;
        end else if (avs_write && !avs_waitrequest && avs_byteenable[0]) begin
            if (avs_address == tcc_pkg::ADDR_CTL) ctl_r <= avs_writedata[6:0];
            if (avs_address == tcc_pkg::ADDR_IOC) mode_r <= avs_writedata[2:0];
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_req;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_ack;
        (avs_read || avs_write) && !avs_waitrequest;
    endsequence

    property p_ack_one;
        s_req |=> !avs_waitrequest;
    endproperty
    a_ack_one: assert property (p_ack_one)
        else $error("bus answer late");
    property p_ack_pulse;
        !avs_waitrequest |=> avs_waitrequest;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("waitrequest low too long");
    property p_unmap;
        s_ack ##0 (avs_read && !(avs_address inside {8'h64, 8'h68, 8'h6c, 8'h70, 8'h74, 8'h78}))
            |-> avs_readdata == 32'h0000_0000;
    endproperty
    a_unmap: assert property (p_unmap)
        else $error("unmapped read not zero");
    property p_ctl_rb;
        s_ack ##0 (avs_read && avs_address == tcc_pkg::ADDR_CTL)
            |-> avs_readdata == {24'h00_0000, 1'b1, ctl_r};
    endproperty
    a_ctl_rb: assert property (p_ctl_rb)
        else $error("control readback wrong");
    property p_oe;
        $stable(mode_r) [*3] |-> ioa_pin_oe == (mode_r != 3'h0 && mode_r < 3'h4);
    endproperty
    a_oe: assert property (p_oe)
        else $error("output enable wrong for mode");
    property p_low;
        mode_r == tcc_pkg::IOA_LOW && !ioa_pin_out |=> !ioa_pin_out;
    endproperty
    a_low: assert property (p_low)
        else $error("pin left low level");
    property p_high;
        mode_r == tcc_pkg::IOA_HIGH && ioa_pin_out |=> ioa_pin_out;
    endproperty
    a_high: assert property (p_high)
        else $error("pin left high level");
    property p_keep;
        mode_r == tcc_pkg::IOA_NONE |=> $stable(ioa_pin_out);
    endproperty
    a_keep: assert property (p_keep)
        else $error("pin moved with no output");
    property p_no_clr;
        (ctl_r[6:5] == tcc_pkg::CLR_NONE) [*3] |-> !clear_event;
    endproperty
    a_no_clr: assert property (p_no_clr)
        else $error("clear with clear source off");
    property p_sync;
        ctl_r[6:5] == tcc_pkg::CLR_SYNC && sync_clear_in |-> ##[0:2] clear_event;
    endproperty
    a_sync: assert property (p_sync)
        else $error("sync clear missed");
endmodule // tcc_top_checker

bind tcc_top tcc_top_checker tcc_top_checker_i (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .ioa_pin_out(ioa_pin_out), .ioa_pin_oe(ioa_pin_oe),
    .sync_clear_in(sync_clear_in), .clear_event(clear_event)
);

`default_nettype wire

// ===== bench/tb_timer_channel_clock_and_gra_control.sv
// Self-checking bench for the timer channel over Avalon-MM.
// Assumes tcc_top, tcc_pin_model and the bound checker are compiled first.
`default_nettype none
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin errors++; \
    $display("ERROR %s expected %h seen %h", n, e, s); end end

module tb_timer_channel_clock_and_gra_control;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  adr = 8'h00;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wd = 32'h0000_0000;
    logic        sync_clr = 1'b0;
    logic [31:0] rdata;
    logic        wait_req;
    logic [3:0]  ext;
    logic        pin_in;
    logic [31:0] rv;
    logic [31:0] seed = 32'h3bc2_bef4;
    logic [32:0] q[$];
    logic [32:0] e;
    int          errors = 0;
    int          tests_run = 0;
    int          n;
    int          g;

    always #25 clk = ~clk;

    tcc_top tcc_top_i (
        .clk(clk), .rst(rst), .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wd), .avs_byteenable(4'hf), .avs_readdata(rdata),
        .avs_waitrequest(wait_req), .ext_clock_in(ext), .ioa_pin_in(pin_in),
        .ioa_pin_out(), .ioa_pin_oe(), .sync_clear_in(sync_clr), .clear_event()
    );
    tcc_pin_model tcc_pin_model_i (.clk(clk), .ext_clock_in(ext), .ioa_pin_in(pin_in));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic report_and_stop;
        $display("Checks %0d, errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // One bus access; a read notes its expectation (c marks it as checked)
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic c, input logic [31:0] x);
        int k = 0;
        @(posedge clk);
        adr <= a;
        wd <= d;
        rd <= !w;
        wr <= w;
        if (!w) q.push_back({c, x});
        do begin
            @(posedge clk);
            k++;
        end while (wait_req !== 1'b0 && k < 20);
        if (k >= 20) begin
            errors++;
            report_and_stop();
        end
        rv = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    // Read answers taken off the queue in order
    always @(posedge clk) begin
        if (rd && wait_req === 1'b0) begin
            e = q.pop_front();
            if (e[32]) `CHK("rdata", e[31:0], rdata)
        end
    end

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        acc(0, tcc_pkg::ADDR_CTL, 0, 1, 32'h0000_0080);
        acc(0, tcc_pkg::ADDR_IOC, 0, 1, 32'h0000_0088);
        acc(0, tcc_pkg::ADDR_GRA, 0, 1, 32'h0000_ffff);
        acc(0, 8'h7c, 0, 1, 32'h0000_0000);
        // Internal divided clocks over a 64-cycle span
        for (int c = 0; c < 4; c++) begin
            acc(1, tcc_pkg::ADDR_CTL, c, 0, 0);
            acc(0, tcc_pkg::ADDR_CNT, 0, 0, 0);
            repeat (61) @(posedge clk);
            acc(0, tcc_pkg::ADDR_CNT, 0, 1, (rv + (64 >> c)) & 32'h0000_ffff);
        end
        // External clocks A-D, each with its own edge code
        for (int p = 0; p < 4; p++) begin
            seed = lfsr(seed);
            n = 1 + seed[2:0];
            acc(1, tcc_pkg::ADDR_CTL, 4 + p + (p << 3), 0, 0);
            acc(0, tcc_pkg::ADDR_CNT, 0, 0, 0);
            tcc_pin_model_i.burst(p, n);
            repeat (8) @(posedge clk);
            acc(0, tcc_pkg::ADDR_CNT, 0, 1, rv + (p > 1 ? 2 * n : n));
        end
        // Capture with the counter frozen on an idle pin
        acc(1, tcc_pkg::ADDR_CTL, 4, 0, 0);
        for (int m = 4; m < 7; m++) begin
            seed = lfsr(seed);
            acc(1, tcc_pkg::ADDR_IOC, m, 0, 0);
            acc(1, tcc_pkg::ADDR_GRA, 0, 0, 0);
            acc(1, tcc_pkg::ADDR_CNT, 32'(seed[15:0]), 0, 0);
            tcc_pin_model_i.cap(1'b1);
            acc(0, tcc_pkg::ADDR_GRA, 0, 1, m == 5 ? 0 : 32'(seed[15:0]));
            acc(1, tcc_pkg::ADDR_CNT, 32'(seed[31:16]), 0, 0);
            tcc_pin_model_i.cap(1'b0);
            acc(0, tcc_pkg::ADDR_GRA, 0, 1, 32'(m == 4 ? seed[15:0] : seed[31:16]));
        end
        // Sync clear versus no clear
        for (int c = 0; c < 4; c += 3) begin
            acc(1, tcc_pkg::ADDR_CTL, 4 + (c << 5), 0, 0);
            acc(1, tcc_pkg::ADDR_CNT, 5, 0, 0);
            @(posedge clk);
            sync_clr <= 1'b1;
            @(posedge clk);
            sync_clr <= 1'b0;
            acc(0, tcc_pkg::ADDR_CNT, 0, 1, c == 3 ? 0 : 5);
        end
        // Clear on register A then register B match: period g+1
        seed = lfsr(seed);
        g = 4 + seed[3:0];
        acc(1, tcc_pkg::ADDR_IOC, 0, 0, 0);
        acc(1, tcc_pkg::ADDR_GRA, g, 0, 0);
        acc(1, tcc_pkg::ADDR_GRB, g, 0, 0);
        for (int c = 1; c < 3; c++) begin
            acc(1, tcc_pkg::ADDR_CTL, c << 5, 0, 0);
            acc(1, tcc_pkg::ADDR_CNT, 0, 0, 0);
            acc(0, tcc_pkg::ADDR_CNT, 0, 0, 0);
            repeat (61) @(posedge clk);
            acc(0, tcc_pkg::ADDR_CNT, 0, 1, (rv + 64) % (g + 1));
        end
        // Compare output: high, low, toggle, no output
        for (int m = 2; m >= 0; m--) begin
            acc(1, tcc_pkg::ADDR_IOC, m == 0 ? 3 : m, 0, 0);
            repeat (40) @(posedge clk);
            acc(0, tcc_pkg::ADDR_STAT, 0, m > 0, m == 2 ? 1 : 0);
        end
        repeat (g - 2) @(posedge clk);
        acc(0, tcc_pkg::ADDR_STAT, 0, 1, rv ^ 32'h0000_0001);
        acc(1, tcc_pkg::ADDR_IOC, 0, 0, 0);
        acc(0, tcc_pkg::ADDR_STAT, 0, 0, 0);
        repeat (40) @(posedge clk);
        acc(0, tcc_pkg::ADDR_STAT, 0, 1, rv);
        report_and_stop();
    end
endmodule // tb_timer_channel_clock_and_gra_control

`default_nettype wire
